/* File: hw/dcm_cfg.svh */
// register map, field positions, reset values and timing counts of the clock and mode block
`ifndef DCM_CFG_SVH
`define DCM_CFG_SVH

`define DCM_ADDR_W 5
`define DCM_OFS_INTERP 5'h01
`define DCM_OFS_FMT_EDGE 5'h02
`define DCM_OFS_LOOP 5'h04

`define DCM_INTERP_HI 7
`define DCM_INTERP_LO 6
`define DCM_FMT_BIT 7
`define DCM_EDGE_BIT 4
`define DCM_LOOP_EN_BIT 7
`define DCM_MULT_HI 6
`define DCM_MULT_LO 5
`define DCM_DIV_HI 4
`define DCM_DIV_LO 3
`define DCM_LOCK_PIN_BIT 0

`define DCM_RST_INTERP 2'h0
`define DCM_RST_FMT 1'h0
`define DCM_RST_EDGE 1'h0
`define DCM_RST_LOOP_EN 1'h0
`define DCM_RST_MULT 2'h0
`define DCM_RST_DIV 2'h0
`define DCM_RST_LOCK_PIN 1'h0

`define DCM_CLK_PERIOD_NS 20
`define DCM_LOCK_TIME_NS 2000
`define DCM_LOCK_CYCLES ((`DCM_LOCK_TIME_NS + `DCM_CLK_PERIOD_NS - 1) / `DCM_CLK_PERIOD_NS)

`endif

/* File: hw/dcm_clock_mode_config.sv */
// mode and clock configuration of the interpolating converter, with sample capture
`timescale 1ns/10ps
`default_nettype none
`include "dcm_cfg.svh"
module dcm_clock_mode_config #(
  parameter int SAMPLE_W = 12,
  parameter int LOCK_CYCLES = `DCM_LOCK_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic csb_n_i,
  input wire logic sclk_i,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe_o,
  input wire logic [SAMPLE_W-1:0] sample_i,
  output logic [SAMPLE_W-1:0] sample_o,
  output logic sample_valid_o,
  output logic data_clock_o,
  output logic sync_enable_o,
  output logic multiplier_loop_enable_o,
  output logic loop_locked_o,
  output logic [4:0] interp_factor_o,
  output logic [4:0] loop_multiplier_o,
  output logic [4:0] loop_divider_o
);
  import dcm_pkg::*;

  localparam int LOCK_W = $clog2(LOCK_CYCLES + 1);
  localparam logic [SAMPLE_W-1:0] MSB_MASK = {1'b1, {(SAMPLE_W-1){1'b0}}};

  typedef struct packed {
    logic [1:0] interp;
    logic sample_format_select;
    logic edge_sel;
    logic multiplier_loop_enable;
    logic [1:0] loop_multiplier;
    logic [1:0] loop_divider;
    logic lock_flag_to_pin;
    logic [LOCK_W-1:0] lock_cnt;
    logic locked;
    logic pin;
    logic [SAMPLE_W-1:0] sample;
    logic valid;
  } dcm_main_regs_type;

  dcm_main_regs_type r;
  dcm_main_regs_type next_r;

  logic [4:0] sp_addr;
  logic [7:0] sp_wdata;
  logic sp_wr;
  logic [7:0] rdata;
  logic [4:0] div_factor;
  logic div_start;
  logic div_mid;
  logic div_level;
  logic capture;
  logic cfg_touch;

  // 2**(code+base): shared decode of interpolation, multiplier and divider codes
  function automatic logic [4:0] dcm_pow2(input logic [1:0] code, input logic base);
    logic [2:0] sh;
    sh = {1'b0, code} + {2'b00, base};
    dcm_pow2 = 5'h01 << sh;
  endfunction

  dcm_serial_port u_port (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .csb_n_i(csb_n_i),
    .sclk_i(sclk_i),
    .sdio_i(sdio_i),
    .sdio_o(sdio_o),
    .sdio_oe_o(sdio_oe_o),
    .rdata_i(rdata),
    .addr_o(sp_addr),
    .wdata_o(sp_wdata),
    .wr_o(sp_wr)
  );

  // with the loop on the input clock already runs at the data rate
  assign div_factor = r.multiplier_loop_enable ? 5'h01 : dcm_pow2(r.interp, 1'b0);

  dcm_rate_divider #(
    .CNT_W(3)
  ) u_div (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .factor_i(div_factor[3:0]),
    .start_o(div_start),
    .mid_o(div_mid),
    .level_o(div_level)
  );

  // rising edge of the data clock is the period start, falling edge its middle
  assign capture = r.edge_sel ? div_mid : div_start;
  assign cfg_touch = sp_wr && (sp_addr == `DCM_OFS_LOOP || sp_addr == `DCM_OFS_INTERP);

  // read-back; undefined bits and unmapped addresses read zero
  always_comb begin
    rdata = 8'h00;
    case (sp_addr)
      `DCM_OFS_INTERP: begin
        rdata[`DCM_INTERP_HI:`DCM_INTERP_LO] = r.interp;
      end
      `DCM_OFS_FMT_EDGE: begin
        rdata[`DCM_FMT_BIT] = r.sample_format_select;
        rdata[`DCM_EDGE_BIT] = r.edge_sel;
      end
      `DCM_OFS_LOOP: begin
        rdata[`DCM_LOOP_EN_BIT] = r.multiplier_loop_enable;
        rdata[`DCM_MULT_HI:`DCM_MULT_LO] = r.loop_multiplier;
        rdata[`DCM_DIV_HI:`DCM_DIV_LO] = r.loop_divider;
        rdata[`DCM_LOCK_PIN_BIT] = r.lock_flag_to_pin;
      end
      default: begin
        rdata = 8'h00;
      end
    endcase
  end

  always_comb begin
    next_r = r;
    if (sp_wr) begin
      case (sp_addr)
        `DCM_OFS_INTERP: begin
          next_r.interp = sp_wdata[`DCM_INTERP_HI:`DCM_INTERP_LO];
        end
        `DCM_OFS_FMT_EDGE: begin
          next_r.sample_format_select = sp_wdata[`DCM_FMT_BIT];
          next_r.edge_sel = sp_wdata[`DCM_EDGE_BIT];
        end
        `DCM_OFS_LOOP: begin
          next_r.multiplier_loop_enable = sp_wdata[`DCM_LOOP_EN_BIT];
          next_r.loop_multiplier = sp_wdata[`DCM_MULT_HI:`DCM_MULT_LO];
          next_r.loop_divider = sp_wdata[`DCM_DIV_HI:`DCM_DIV_LO];
          next_r.lock_flag_to_pin = sp_wdata[`DCM_LOCK_PIN_BIT];
        end
        default: begin
          next_r.interp = r.interp;
        end
      endcase
    end
    // lock model: any change to the loop or rate setting restarts acquisition
    if (!r.multiplier_loop_enable || cfg_touch) begin
      next_r.lock_cnt = '0;
      next_r.locked = 1'b0;
    end else if (r.lock_cnt != LOCK_W'(LOCK_CYCLES)) begin
      next_r.lock_cnt = r.lock_cnt + 1'b1;
      next_r.locked = 1'b0;
    end else begin
      next_r.locked = 1'b1;
    end
    // pin shows lock whenever the loop runs or lock is routed out
    if (r.multiplier_loop_enable || r.lock_flag_to_pin) begin
      next_r.pin = r.locked;
    end else begin
      next_r.pin = div_level;
    end
    next_r.valid = capture;
    if (capture) begin
      // offset binary goes to two's complement by flipping the sign bit
      next_r.sample = r.sample_format_select ? (sample_i ^ MSB_MASK) : sample_i;
    end
  end

  // synchronous hard reset restores every default
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r <= '0;
      r.interp <= `DCM_RST_INTERP;
      r.sample_format_select <= `DCM_RST_FMT;
      r.edge_sel <= `DCM_RST_EDGE;
      r.multiplier_loop_enable <= `DCM_RST_LOOP_EN;
      r.loop_multiplier <= `DCM_RST_MULT;
      r.loop_divider <= `DCM_RST_DIV;
      r.lock_flag_to_pin <= `DCM_RST_LOCK_PIN;
    end else begin
      r <= next_r;
    end
  end

  assign sample_o = r.sample;
  assign sample_valid_o = r.valid;
  assign data_clock_o = r.pin;
  assign sync_enable_o = ~r.lock_flag_to_pin;
  assign multiplier_loop_enable_o = r.multiplier_loop_enable;
  assign loop_locked_o = r.locked;
  assign interp_factor_o = dcm_pow2(r.interp, 1'b0);
  assign loop_multiplier_o = dcm_pow2(r.loop_multiplier, 1'b1);
  assign loop_divider_o = dcm_pow2(r.loop_divider, 1'b0);

  // helper: cycles between captures while no setting changed
  logic [4:0] gap;
  logic gap_ok;
  logic [1:0] wr_interp;
  assign wr_interp = sp_wdata[`DCM_INTERP_HI:`DCM_INTERP_LO];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      gap <= 5'h00;
      gap_ok <= 1'b0;
    end else if (capture) begin
      gap <= 5'h01;
      gap_ok <= ~sp_wr;
    end else begin
      gap <= (gap == 5'h1f) ? gap : gap + 5'h01;
      gap_ok <= gap_ok & ~sp_wr;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_loop_on;
    $rose(r.multiplier_loop_enable);
  endsequence

  sequence s_unlocked;
    (!r.locked && !data_clock_o) [*8];
  endsequence

  a_reset_defaults: assert property ($past(reset_i) |-> (interp_factor_o == 5'h01)
      && !multiplier_loop_enable_o && !r.sample_format_select && !r.edge_sel && sync_enable_o)
    else $error("configuration not at defaults after reset");
  a_fmt_offset: assert property ((capture && r.sample_format_select)
      |=> sample_valid_o && sample_o == ($past(sample_i) ^ MSB_MASK))
    else $error("offset binary sample not converted");
  a_fmt_twos: assert property ((capture && !r.sample_format_select)
      |=> sample_valid_o && sample_o == $past(sample_i))
    else $error("two's complement sample altered");
  a_interp_write: assert property ((sp_wr && sp_addr == `DCM_OFS_INTERP)
      |=> interp_factor_o == (5'h01 << $past(wr_interp)))
    else $error("interpolation factor does not follow the write");
  a_capture_gap: assert property ((capture && gap_ok) |-> gap == div_factor)
    else $error("capture spacing differs from the rate factor");
  a_pin_lock: assert property (r.multiplier_loop_enable |=> data_clock_o == $past(r.locked))
    else $error("data clock pin does not show lock while the loop runs");
  a_lock_routed: assert property (r.lock_flag_to_pin |-> !sync_enable_o ##1 data_clock_o == $past(r.locked))
    else $error("lock routing or synchronizer disable wrong");
  a_lock_wait: assert property (s_loop_on |=> s_unlocked)
    else $error("lock reported too soon after loop enable");
  a_edge_select: assert property ((capture && gap_ok && div_factor > 5'h01
      && !r.multiplier_loop_enable && !r.lock_flag_to_pin)
      |=> ($past(r.edge_sel) ? $fell(data_clock_o) : $rose(data_clock_o)))
    else $error("capture on the wrong data clock edge");

  // register writes land on the next edge
  a_loop_write: assert property ((sp_wr && sp_addr == `DCM_OFS_LOOP) |=>
      multiplier_loop_enable_o == $past(sp_wdata[`DCM_LOOP_EN_BIT])
      && loop_multiplier_o == (5'h02 << $past(sp_wdata[`DCM_MULT_HI:`DCM_MULT_LO])))
    else $error("loop enable or multiplier does not follow the write");
  a_div_write: assert property ((sp_wr && sp_addr == `DCM_OFS_LOOP) |=>
      loop_divider_o == (5'h01 << $past(sp_wdata[`DCM_DIV_HI:`DCM_DIV_LO])))
    else $error("loop divider does not follow the write");
  a_sync_follow: assert property ((sp_wr && sp_addr == `DCM_OFS_LOOP) |=>
      sync_enable_o == !$past(sp_wdata[`DCM_LOCK_PIN_BIT]))
    else $error("synchronizer enable does not follow the lock routing bit");
  a_fmt_write: assert property ((sp_wr && sp_addr == `DCM_OFS_FMT_EDGE) |=>
      r.sample_format_select == $past(sp_wdata[`DCM_FMT_BIT]) && r.edge_sel == $past(sp_wdata[`DCM_EDGE_BIT]))
    else $error("format or latch edge does not follow the write");

  // lock flag
  a_unlock_off: assert property (!r.multiplier_loop_enable |=>
      !loop_locked_o)
    else $error("lock reported with the loop off");
  a_lock_clear: assert property (cfg_touch |=>
      !loop_locked_o)
    else $error("lock kept across a loop or rate change");
  a_lock_hold: assert property ((r.locked && r.multiplier_loop_enable && !cfg_touch) |=>
      loop_locked_o)
    else $error("lock dropped without a setting change");

  // sample path and outputs after reset
  a_loop_rate: assert property ((r.multiplier_loop_enable && $past(r.multiplier_loop_enable)) |=>
      sample_valid_o)
    else $error("sample not taken every clock with the loop on");
  a_sample_hold: assert property (!capture |=>
      $stable(sample_o) && !sample_valid_o)
    else $error("sample changed between captures");
  a_reset_outputs: assert property ($past(reset_i) |->
      !sample_valid_o && sample_o == '0 && !sdio_oe_o && !loop_locked_o)
    else $error("outputs not cleared by reset");

endmodule
`default_nettype wire

/* File: hw/dcm_pkg.sv */
// types shared by the clock and mode block
package dcm_pkg;

  typedef enum logic [1:0] {SP_INSTR, SP_LOAD, SP_DATA, SP_DONE} dcm_sp_state_type;

  typedef struct packed {
    dcm_sp_state_type state;
    logic sclk_q;
    logic [3:0] bit_cnt;
    logic read;
    logic [4:0] addr;
    logic [7:0] shift;
    logic sdo_en;
    logic wr_stb;
  } dcm_sp_regs_type;

  typedef struct packed {
    logic [2:0] cnt;
    logic level;
  } dcm_div_regs_type;

endpackage

/* File: hw/dcm_rate_divider.sv */
// divides the input clock by a power-of-two factor into period and mid-period strobes
`timescale 1ns/10ps
`default_nettype none
module dcm_rate_divider #(
  parameter int CNT_W = 3
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [CNT_W:0] factor_i,
  output logic start_o,
  output logic mid_o,
  output logic level_o
);
  import dcm_pkg::*;

  dcm_div_regs_type r;
  dcm_div_regs_type next_r;
  logic [CNT_W:0] cnt_ext;
  logic [CNT_W:0] next_cnt_ext;

  assign cnt_ext = {1'b0, r.cnt};
  assign start_o = (r.cnt == '0);
  // factor 1 puts both strobes in the same cycle
  assign mid_o = (cnt_ext == (factor_i >> 1));
  assign level_o = r.level;

  always_comb begin
    next_r = r;
    // a shrunken factor wraps at once instead of running out the old period
    if (cnt_ext >= factor_i - 1'b1) begin
      next_cnt_ext = '0;
    end else begin
      next_cnt_ext = cnt_ext + 1'b1;
    end
    next_r.cnt = next_cnt_ext[CNT_W-1:0];
    next_r.level = (next_cnt_ext < ((factor_i + 1'b1) >> 1));
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule
`default_nettype wire

/* File: hw/dcm_serial_port.sv */
// serial control port slave: 16-bit frames, instruction byte then one data byte
`timescale 1ns/10ps
`default_nettype none
module dcm_serial_port (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic csb_n_i,
  input wire logic sclk_i,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe_o,
  input wire logic [7:0] rdata_i,
  output logic [4:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o
);
  import dcm_pkg::*;

  dcm_sp_regs_type r;
  dcm_sp_regs_type next_r;
  logic rise;
  logic fall;

  // sclk is oversampled, so it must stay at least two clocks in each level
  assign rise = sclk_i & ~r.sclk_q;
  assign fall = ~sclk_i & r.sclk_q;
  assign sdio_o = r.shift[7];
  assign sdio_oe_o = r.sdo_en;
  assign addr_o = r.addr;
  assign wdata_o = r.shift;
  assign wr_o = r.wr_stb;

  always_comb begin
    next_r = r;
    next_r.sclk_q = sclk_i;
    next_r.wr_stb = 1'b0;
    if (csb_n_i) begin
      next_r.state = SP_INSTR;
      next_r.bit_cnt = 4'h0;
      next_r.sdo_en = 1'b0;
    end else begin
      case (r.state)
        SP_INSTR: begin
          if (rise) begin
            next_r.shift = {r.shift[6:0], sdio_i};
            next_r.bit_cnt = r.bit_cnt + 4'h1;
            if (r.bit_cnt == 4'h7) begin
              next_r.read = r.shift[6];
              next_r.addr = {r.shift[3:0], sdio_i};
              next_r.bit_cnt = 4'h0;
              next_r.state = SP_LOAD;
            end
          end
        end
        SP_LOAD: begin
          next_r.state = SP_DATA;
          if (r.read) begin
            next_r.shift = rdata_i;
            next_r.sdo_en = 1'b1;
          end
        end
        SP_DATA: begin
          if (rise) begin
            next_r.bit_cnt = r.bit_cnt + 4'h1;
            if (!r.read) begin
              next_r.shift = {r.shift[6:0], sdio_i};
            end
            if (r.bit_cnt == 4'h7) begin
              next_r.state = SP_DONE;
              next_r.wr_stb = ~r.read;
            end
          end else if (fall && r.read && r.bit_cnt != 4'h0) begin
            next_r.shift = {r.shift[6:0], 1'b0};
          end
        end
        SP_DONE: begin
          if (fall) begin
            next_r.sdo_en = 1'b0;
          end
        end
        default: begin
          next_r.state = SP_INSTR;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule
`default_nettype wire

/* File: verif/dcm_clock_mode_config_test.sv */
// self-checking bench of the clock and mode block
`timescale 1ns/10ps
`default_nettype none
module dcm_clock_mode_config_test;
  localparam int LOCKC = 20;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [11:0] sample_in = 12'h000;
  logic csb_n, sclk, sdio_in, sdio_out, sdio_oe;
  logic [11:0] sample_out;
  logic sample_valid, data_clock, sync_enable, loop_en, locked;
  logic [4:0] interp_factor, loop_mult, loop_div;
  logic [11:0] corner [4] = '{12'h800, 12'h7ff, 12'h000, 12'hfff};
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 65784;
  int k, n, r, j;

  // one 50 MHz source stands in for the converter clock
  initial begin
    forever #10 clk_i = ~clk_i;
  end

  dcm_host_model host (.clk_i(clk_i), .dev_sdio_i(sdio_out), .dev_oe_i(sdio_oe),
    .csb_n_o(csb_n), .sclk_o(sclk), .sdio_o(sdio_in));

  dcm_clock_mode_config #(.SAMPLE_W(12), .LOCK_CYCLES(LOCKC)) dut (.clk_i(clk_i), .reset_i(reset_i),
    .csb_n_i(csb_n), .sclk_i(sclk), .sdio_i(sdio_in), .sdio_o(sdio_out), .sdio_oe_o(sdio_oe),
    .sample_i(sample_in), .sample_o(sample_out), .sample_valid_o(sample_valid),
    .data_clock_o(data_clock), .sync_enable_o(sync_enable), .multiplier_loop_enable_o(loop_en),
    .loop_locked_o(locked), .interp_factor_o(interp_factor), .loop_multiplier_o(loop_mult),
    .loop_divider_o(loop_div));

  function automatic logic [31:0] exp_factor(input logic [1:0] c);
    return 32'h1 << c;
  endfunction

  function automatic logic [11:0] exp_sample(input logic [11:0] s, input logic f);
    return f ? {~s[11], s[10:0]} : s;
  endfunction

  task test_done;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] unused;
    host.frame(1'b0, a, d, unused);
  endtask

  task rdchk(input string what, input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] got;
    host.frame(1'b1, a, 8'h00, got);
    check(what, {24'h0, exp}, {24'h0, got});
  endtask

  task do_reset;
    @(negedge clk_i) reset_i = 1'b1;
    repeat (10) @(negedge clk_i);
    reset_i = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask

  task check_defaults;
    check("interp", 1, {27'h0, interp_factor});
    check("loop_en", 0, {31'h0, loop_en});
    check("mult", 2, {27'h0, loop_mult});
    check("div", 1, {27'h0, loop_div});
    check("sync_en", 1, {31'h0, sync_enable});
    rdchk("reg01", 5'h01, 8'h00);
    rdchk("reg02", 5'h02, 8'h00);
    rdchk("reg04", 5'h04, 8'h00);
  endtask

  // counts capture pulses and pin rises over a window of 64 clocks
  task count_rate(output int nv, output int nr);
    logic prev;
    nv = 0;
    nr = 0;
    prev = data_clock;
    repeat (64) begin
      @(negedge clk_i);
      if (sample_valid === 1'b1) nv++;
      if (data_clock === 1'b1 && prev === 1'b0) nr++;
      prev = data_clock;
    end
  endtask

  task wait_valid;
    int t;
    t = 0;
    @(negedge clk_i);
    while (sample_valid !== 1'b1 && t < 40) begin
      @(negedge clk_i);
      t++;
    end
    if (t >= 40) check("valid_wait", 1, 0);
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles >= 20000) begin
      bad_count++;
      test_done();
    end
  end

  initial begin
    do_reset();
    check_defaults();
    $display("test reset defaults done");
    for (k = 0; k < 4; k++) begin
      wr(5'h01, {k[1:0], 6'h00});
      check("interp", exp_factor(k[1:0]), {27'h0, interp_factor});
      rdchk("reg01", 5'h01, {k[1:0], 6'h00});
      count_rate(n, r);
      check("valid_rate", 64 / exp_factor(k[1:0]), n);
      check("pin_rises", k == 0 ? 0 : 64 / exp_factor(k[1:0]), r);
    end
    $display("test interpolation rates done");
    for (k = 0; k < 2; k++) begin
      wr(5'h02, {3'h0, k[0], 4'h0});
      repeat (4) begin
        wait_valid();
        check("pin_at_capture", {31'h0, ~k[0]}, {31'h0, data_clock});
      end
    end
    $display("test latch edge done");
    wr(5'h01, 8'h00);
    for (k = 0; k < 2; k++) begin
      wr(5'h02, {k[0], 7'h00});
      for (j = 0; j < 8; j++) begin
        @(negedge clk_i) sample_in = (j < 4) ? corner[j] : 12'($random(seed));
        repeat (3) @(negedge clk_i);
        check("sample", {20'h0, exp_sample(sample_in, k[0])}, {20'h0, sample_out});
      end
    end
    $display("test sample format done");
    // multiplier over divider stays 2, matching 2x interpolation
    wr(5'h01, 8'h40);
    for (k = 0; k < 4; k++) begin
      wr(5'h04, {1'b1, k[1:0], k[1:0], 3'h0});
      check("loop_en", 1, {31'h0, loop_en});
      check("mult", exp_factor(k[1:0]) * 2, {27'h0, loop_mult});
      check("div", exp_factor(k[1:0]), {27'h0, loop_div});
      check("lock_early", 0, {31'h0, locked});
      check("pin_early", 0, {31'h0, data_clock});
      count_rate(n, r);
      check("valid_rate_loop", 64, n);
      check("locked", 1, {31'h0, locked});
      check("pin_lock", 1, {31'h0, data_clock});
    end
    $display("test loop settings done");
    wr(5'h04, 8'h01);
    check("sync_en", 0, {31'h0, sync_enable});
    check("pin_flag", 0, {31'h0, data_clock});
    rdchk("reg04", 5'h04, 8'h01);
    wr(5'h03, 8'hff);
    rdchk("reg03", 5'h03, 8'h00);
    rdchk("reg01", 5'h01, 8'h40);
    $display("test lock pin and unmapped done");
    wr(5'h02, 8'h90);
    wr(5'h04, 8'ha8);
    do_reset();
    check_defaults();
    $display("test mid-run reset done");
    test_done();
  end
endmodule
`default_nettype wire

/* File: verif/dcm_host_model.sv */
// serial port host facing the clock and mode block
`timescale 1ns/10ps
`default_nettype none
module dcm_host_model (
  input wire logic clk_i,
  input wire logic dev_sdio_i,
  input wire logic dev_oe_i,
  output logic csb_n_o,
  output logic sclk_o,
  output logic sdio_o
);
  logic drv;
  logic drv_en;
  logic last;

  initial begin
    csb_n_o = 1'b1;
    sclk_o = 1'b0;
    drv = 1'b0;
    drv_en = 1'b0;
  end

  // released line has no pull: show a changing pattern, never a stale bit
  always @(posedge clk_i) last <= sdio_o;
  assign sdio_o = dev_oe_i ? dev_sdio_i : (drv_en ? drv : ~last);

  // one 16-bit frame, levels held 3 clocks since the port oversamples
  task frame(input logic rd, input logic [4:0] addr, input logic [7:0] wd, output logic [7:0] rdat);
    logic [15:0] word;
    int i;
    word = {rd, 2'h0, addr, wd};
    rdat = 8'h00;
    @(negedge clk_i) csb_n_o = 1'b0;
    drv_en = 1'b1;
    for (i = 15; i >= 0; i--) begin
      @(negedge clk_i) sclk_o = 1'b0;
      drv = word[i];
      if (rd && i < 8) drv_en = 1'b0;
      repeat (3) @(negedge clk_i);
      if (i < 8) rdat[i] = sdio_o;
      sclk_o = 1'b1;
      repeat (2) @(negedge clk_i);
    end
    repeat (3) @(negedge clk_i);
    sclk_o = 1'b0;
    @(negedge clk_i) csb_n_o = 1'b1;
    drv_en = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire
